// File: sacc_ctrl.sv
// Conversion control for a ten-bit successive-approximation converter: APB registers,
// prescaler, start and auto-trigger logic, sample-and-hold timing and result locking.
// Assumes the analog array delivers its ten-bit code when the conversion completes.

`default_nettype none

module sacc_ctrl
  import sacc_pkg::*;
#(
  parameter int NUM_TRIG = 8,
  parameter int NUM_PRESC = 8,
  parameter int PRESC_DIV_W = 8,
  parameter logic [8*PRESC_DIV_W-1:0] PRESC_DIVS = {8'h80, 8'h40, 8'h20, 8'h10,
                                                    8'h08, 8'h04, 8'h02, 8'h02}
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [NUM_TRIG-1:0] trigger_sources_i,
  input wire logic [9:0] conv_code_i,
  output logic [3:0] input_channel_select_o,
  output logic [1:0] reference_select_o,
  output logic analog_enable_o,
  output logic sample_hold_o,
  output logic conv_clk_en_o,
  output logic conversion_done_o
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic converter_enable_q;
  logic start_conversion_q;
  logic auto_trigger_enable_q;
  logic conversion_complete_flag_q;
  logic converter_power_reduction_q;
  logic [2:0] prescaler_select_q;
  logic [2:0] trigger_source_select_q;
  logic [7:0] channel_reference_register_q;
  logic [7:0] chref_temp_q;
  logic [9:0] result_q;
  logic locked_q;
  logic busy_q;
  logic first_q;
  logic auto_conv_q;
  logic [5:0] half_cnt_q;
  logic [7:0] presc_cnt_q;
  logic conv_clk_en_q;
  logic trig_prev_q;
  logic [1:0] trig_sync_q;
  logic done_q;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;

  wire logic wr = psel_i && penable_i && pwrite_i;
  wire logic rd = psel_i && penable_i && !pwrite_i;
  wire logic start_wr = wr && paddr_i == SACC_OFF_CTRL_A && pwdata_i[SACC_A_START]
    && pwdata_i[SACC_A_ENABLE] && !pwdata_i[SACC_A_PWRRED] && !converter_power_reduction_q;

  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;

  // --------------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------------
  logic [PRESC_DIV_W-1:0] div_sel;
  logic trig_fire;
  assign div_sel = PRESC_DIVS[prescaler_select_q*PRESC_DIV_W +: PRESC_DIV_W];

  // The prescaler is reset on a trigger so the delay to hold is fixed.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      presc_cnt_q <= 8'h00;
      conv_clk_en_q <= 1'b0;
    end else if (!converter_enable_q || trig_fire) begin
      presc_cnt_q <= 8'h00;
      conv_clk_en_q <= 1'b0;
    end else if (presc_cnt_q >= 8'(div_sel - 1'b1)) begin
      presc_cnt_q <= 8'h00;
      conv_clk_en_q <= 1'b1;
    end else begin
      presc_cnt_q <= presc_cnt_q + 8'h01;
      conv_clk_en_q <= 1'b0;
    end
  end
  assign conv_clk_en_o = conv_clk_en_q;

  // --------------------------------------------------------------------------
  // Trigger synchronisation and edge detection
  // --------------------------------------------------------------------------
  logic trig_sel;
  assign trig_sel = (trigger_source_select_q == 3'(SACC_TRIG_FREE))
    ? conversion_complete_flag_q : trigger_sources_i[trigger_source_select_q];

  // Two sync stages plus the edge register make the three extra CPU cycles.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trig_sync_q <= 2'h0;
      trig_prev_q <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[0], trig_sel};
      trig_prev_q <= trig_sync_q[1];
    end
  end

  logic free_run;
  assign free_run = trigger_source_select_q == 3'(SACC_TRIG_FREE);
  // Edges while busy are dropped; a held level gives no new edge.
  assign trig_fire = converter_enable_q && auto_trigger_enable_q && !free_run && !busy_q
    && trig_sync_q[1] && !trig_prev_q;

  // --------------------------------------------------------------------------
  // Conversion sequencer in half converter cycles
  // --------------------------------------------------------------------------
  logic [5:0] end_half;
  logic [5:0] hold_half;
  logic half_tick;
  logic conv_end;
  assign end_half = auto_conv_q ? 6'(SACC_CONV_AUTO_HALF)
    : first_q ? 6'(2*SACC_CONV_FIRST) : 6'(2*SACC_CONV_NORMAL);
  assign hold_half = auto_conv_q ? 6'(SACC_HOLD_AUTO_HALF)
    : first_q ? 6'(SACC_HOLD_FIRST_HALF) : 6'(SACC_HOLD_NORMAL_HALF);
  assign half_tick = conv_clk_en_q || presc_cnt_q == 8'(div_sel >> 1);
  assign conv_end = busy_q && half_tick && half_cnt_q + 6'h01 >= end_half;

  logic restart;
  assign restart = conv_end && auto_trigger_enable_q && free_run;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_q <= 1'b0;
      half_cnt_q <= 6'h00;
      auto_conv_q <= 1'b0;
      first_q <= 1'b1;
      sample_hold_o <= 1'b0;
    end else if (!converter_enable_q) begin
      busy_q <= 1'b0;
      half_cnt_q <= 6'h00;
      first_q <= 1'b1;
      sample_hold_o <= 1'b0;
    end else if (trig_fire) begin
      busy_q <= 1'b1;
      auto_conv_q <= 1'b1;
      half_cnt_q <= 6'h00;
      sample_hold_o <= 1'b0;
    end else if (conv_end) begin
      busy_q <= restart;
      first_q <= 1'b0;
      auto_conv_q <= 1'b0;
      half_cnt_q <= 6'h00;
      sample_hold_o <= 1'b0;
    end else if (!busy_q && start_conversion_q && conv_clk_en_q) begin
      busy_q <= 1'b1;
      auto_conv_q <= 1'b0;
      half_cnt_q <= 6'h00;
    end else if (busy_q && half_tick) begin
      half_cnt_q <= half_cnt_q + 6'h01;
      if (half_cnt_q + 6'h01 == hold_half) begin
        sample_hold_o <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control register A and start bit
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      converter_enable_q <= 1'b0;
      auto_trigger_enable_q <= 1'b0;
      converter_power_reduction_q <= 1'b1;
      prescaler_select_q <= 3'h0;
      trigger_source_select_q <= 3'h0;
    end else if (wr && paddr_i == SACC_OFF_CTRL_A) begin
      converter_enable_q <= pwdata_i[SACC_A_ENABLE] && !pwdata_i[SACC_A_PWRRED];
      auto_trigger_enable_q <= pwdata_i[SACC_A_AUTO];
      converter_power_reduction_q <= pwdata_i[SACC_A_PWRRED];
      prescaler_select_q <= pwdata_i[2:0];
    end else if (wr && paddr_i == SACC_OFF_CTRL_B) begin
      trigger_source_select_q <= pwdata_i[2:0];
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      start_conversion_q <= 1'b0;
    end else if (start_wr || trig_fire) begin
      // Enable and start may arrive in one write, so the start outranks the old enable.
      start_conversion_q <= 1'b1;
    end else if (!converter_enable_q) begin
      start_conversion_q <= 1'b0;
    end else if (conv_end && !restart) begin
      start_conversion_q <= 1'b0;
    end
  end

  // Hardware set wins over a write-one clear in the same cycle.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conversion_complete_flag_q <= 1'b0;
    end else if (conv_end) begin
      conversion_complete_flag_q <= 1'b1;
    end else if (wr && paddr_i == SACC_OFF_CTRL_A && pwdata_i[SACC_A_FLAG]) begin
      conversion_complete_flag_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Channel and reference selection through the temporary register
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      channel_reference_register_q <= SACC_RST_CHREF;
    end else if (wr && paddr_i == SACC_OFF_CHREF) begin
      channel_reference_register_q <= pwdata_i[7:0];
    end
  end

  logic in_last_cycle;
  assign in_last_cycle = half_cnt_q + 6'h02 >= end_half;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      chref_temp_q <= SACC_RST_CHREF;
    end else if (converter_enable_q && (!busy_q || in_last_cycle)) begin
      chref_temp_q <= channel_reference_register_q;
    end
  end
  assign input_channel_select_o = chref_temp_q[3:0];
  assign reference_select_o = chref_temp_q[SACC_CH_REF_LSB +: 2];
  assign analog_enable_o = converter_enable_q;

  // --------------------------------------------------------------------------
  // Result and lock
  // --------------------------------------------------------------------------
  wire logic rd_lo = rd && paddr_i == SACC_OFF_RES_LO;
  wire logic rd_hi = rd && paddr_i == SACC_OFF_RES_HI;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      locked_q <= 1'b0;
    end else if (rd_hi) begin
      locked_q <= 1'b0;
    end else if (rd_lo) begin
      locked_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_q <= 10'h000;
      done_q <= 1'b0;
    end else begin
      done_q <= conv_end;
      if (conv_end && !locked_q) begin
        result_q <= conv_code_i;
      end
    end
  end
  assign conversion_done_o = done_q;

  always_comb begin
    if (channel_reference_register_q[SACC_CH_LEFT]) begin
      result_high_byte = result_q[9:2];
      result_low_byte = {result_q[1:0], 6'h00};
    end else begin
      result_high_byte = {6'h00, result_q[9:8]};
      result_low_byte = result_q[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        SACC_OFF_CTRL_A: prdata_o <= {24'h0, converter_enable_q, start_conversion_q,
          auto_trigger_enable_q, conversion_complete_flag_q, converter_power_reduction_q,
          prescaler_select_q};
        SACC_OFF_CTRL_B: prdata_o <= {29'h0, trigger_source_select_q};
        SACC_OFF_CHREF: prdata_o <= {24'h0, channel_reference_register_q};
        SACC_OFF_RES_LO: prdata_o <= {24'h0, result_low_byte};
        SACC_OFF_RES_HI: prdata_o <= {24'h0, result_high_byte};
        SACC_OFF_STATUS: prdata_o <= {29'h0, first_q, locked_q, busy_q};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: sacc_pkg.sv
// Package for the converter conversion-control block: register map, field positions,
// reset values and conversion timing in converter clock cycles.
// Assumes an APB slave with 32-bit data, one register per aligned word.
//
// Contract
// - Channel and reference apply only once enabled.
// - Prescaler runs while enabled, held reset otherwise.
// - Converter clock divided from CPU clock.
// - Ten-bit result, right or left aligned.
// - Low byte read locks result updates.
// - High byte read unlocks result updates.
// - Complete flag set even when result discarded.
// - Start bit starts, reads high, self-clears.
// - Channel change applies after current conversion.
// - Trigger rising edge resets prescaler, starts conversion.
// - Edges during conversion ignored, no level retrigger.
// - Trigger flags set regardless; software clears them.
// - Free running continues regardless of flag clearing.
// - Start bit works under auto trigger, reads busy.
// - Start-bit conversion begins next converter clock edge.
// - Normal conversion 13 cycles, first 25.
// - Hold at 1.5 normal, 13.5 first.
// - Completion writes result, sets flag, clears start.
// - Auto-trigger hold at 2, total 13.5.
// - Free running restarts immediately, start stays high.
// - Input select covers pins, ground, bandgap.
// - Selection tracks, freezes, resumes in last cycle.

`default_nettype none

package sacc_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] SACC_OFF_CTRL_A = 8'h00;
  localparam logic [7:0] SACC_OFF_CTRL_B = 8'h04;
  localparam logic [7:0] SACC_OFF_CHREF = 8'h08;
  localparam logic [7:0] SACC_OFF_RES_LO = 8'h0c;
  localparam logic [7:0] SACC_OFF_RES_HI = 8'h10;
  localparam logic [7:0] SACC_OFF_STATUS = 8'h14;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int SACC_A_ENABLE = 7;
  localparam int SACC_A_START = 6;
  localparam int SACC_A_AUTO = 5;
  localparam int SACC_A_FLAG = 4;
  localparam int SACC_A_PWRRED = 3;
  localparam int SACC_CH_LEFT = 5;
  localparam int SACC_CH_REF_LSB = 6;
  localparam int SACC_TRIG_FREE = 0;

  localparam logic [7:0] SACC_RST_CTRL_A = 8'h08;
  localparam logic [7:0] SACC_RST_CHREF = 8'h00;

  // --------------------------------------------------------------------------
  // Timing in converter clock cycles (half cycles where a half is printed; trigger sync in CPU cycles)
  // --------------------------------------------------------------------------
  localparam int SACC_CONV_NORMAL = 13;
  localparam int SACC_CONV_FIRST = 25;
  localparam int SACC_HOLD_NORMAL_HALF = 3;
  localparam int SACC_HOLD_FIRST_HALF = 27;
  localparam int SACC_HOLD_AUTO_HALF = 4;
  localparam int SACC_CONV_AUTO_HALF = 27;
  localparam int SACC_TRIG_SYNC_CYCLES = 3;

endpackage

`default_nettype wire

// File: sacc_ctrl_monitor.sv
// Checker for the conversion-control block, bound to every instance of it.
// Assumes one-cycle pulses on conv_clk_en_o and conversion_done_o, as delivered.
`default_nettype none
module sacc_ctrl_monitor
  import sacc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] input_channel_select_o,
  input wire logic analog_enable_o,
  input wire logic sample_hold_o,
  input wire logic conv_clk_en_o,
  input wire logic conversion_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] hold_cnt_q;
  logic start_wr;
  // Only fast prescales are watched, so that a first conversion fits the bounded wait.
  assign start_wr = psel_i && penable_i && pwrite_i && paddr_i == SACC_OFF_CTRL_A &&
                    pwdata_i[SACC_A_START] && pwdata_i[SACC_A_ENABLE] &&
                    !pwdata_i[SACC_A_PWRRED] && pwdata_i[2:0] <= 3'h3 && analog_enable_o;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_cnt_q <= 5'h00;
    end else if (!sample_hold_o) begin
      hold_cnt_q <= 5'h00;
    end else if (conv_clk_en_o) begin
      hold_cnt_q <= hold_cnt_q + 5'h01;
    end
  end
  default clocking mon_cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  AST_PRESC_HELD: assert property (
    !analog_enable_o && !$past(analog_enable_o) |-> !conv_clk_en_o)
    else $error("converter clock ticks while disabled");
  AST_TICK_PULSE: assert property (conv_clk_en_o |=> !conv_clk_en_o)
    else $error("converter clock tick wider than one cycle");
  AST_DONE_PULSE: assert property (conversion_done_o |=> !conversion_done_o)
    else $error("completion pulse wider than one cycle");
  AST_SEL_GATED: assert property (
    $changed(input_channel_select_o) |-> analog_enable_o || $past(analog_enable_o))
    else $error("channel selection applied while disabled");
  AST_HOLD_ENABLED: assert property ($rose(sample_hold_o) |-> $past(analog_enable_o))
    else $error("hold while disabled");
  AST_SEL_FROZEN: assert property (
    sample_hold_o && $past(sample_hold_o) && hold_cnt_q < 5'h09
    |-> $stable(input_channel_select_o))
    else $error("channel changed during conversion");
  AST_HOLD_SPAN: assert property (
    $fell(sample_hold_o) && analog_enable_o |-> hold_cnt_q inside {[5'h0a:5'h0d]})
    else $error("hold to completion span wrong");
  AST_HOLD_TO_DONE: assert property (
    $fell(sample_hold_o) && analog_enable_o |-> ##[0:2] conversion_done_o)
    else $error("no completion after hold");
  AST_START_HOLDS: assert property (start_wr |-> ##[1:300] sample_hold_o)
    else $error("start write gave no conversion");
  cover property ($rose(sample_hold_o));
  cover property (start_wr);
  cover property (conversion_done_o && analog_enable_o);
endmodule
bind sacc_ctrl sacc_ctrl_monitor sacc_ctrl_monitor_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .input_channel_select_o(input_channel_select_o),
  .analog_enable_o(analog_enable_o), .sample_hold_o(sample_hold_o),
  .conv_clk_en_o(conv_clk_en_o), .conversion_done_o(conversion_done_o));
`default_nettype wire

// File: sacc_analog_model.sv
// Behavioural sample-and-hold array: the code names the reference and channel held.
// Assumes the code is sampled while the hold is closed; from one cycle after release the code is inverted.
`default_nettype none
module sacc_analog_model (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] channel_i,
  input wire logic [1:0] reference_i,
  input wire logic hold_i,
  output logic [9:0] code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] held_q;
  logic hold_q;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      held_q <= 10'h000;
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold_i;
      if (hold_i && !hold_q) begin
        held_q <= {reference_i, channel_i, 4'h9};
      end
    end
  end
  // One cycle of grace after release, then the code is deliberately wrong.
  assign code_o = (hold_i || hold_q) ? held_q : ~held_q;
endmodule
`default_nettype wire

// File: tb_sacc_ctrl.sv
// Self-checking bench for the conversion-control block with the analog array model.
// Assumes prescale index 0 divides by 2 and trigger 0 selects free running.
`default_nettype none
module tb_sacc_ctrl
  import sacc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [3:0] ch; logic [1:0] rf; logic left; logic [2:0] ps;
    logic [7:0] lo; logic [7:0] hi;} sacc_row_t;
  localparam logic [31:0] EN = 32'h1 << SACC_A_ENABLE;
  localparam logic [31:0] ST = 32'h1 << SACC_A_START;
  localparam logic [31:0] AU = 32'h1 << SACC_A_AUTO;
  localparam logic [31:0] FL = 32'h1 << SACC_A_FLAG;
  localparam logic [31:0] PR = 32'h1 << SACC_A_PWRRED;
  sacc_row_t rows [4] = '{'{4'h3, 2'h1, 1'b0, 3'h0, 8'h39, 8'h01},
    '{4'he, 2'h3, 1'b1, 3'h1, 8'h40, 8'hfa}, '{4'hf, 2'h0, 1'b0, 3'h2, 8'hf9, 8'h00},
    '{4'h0, 2'h2, 1'b1, 3'h3, 8'h40, 8'h82}};
  logic clock_i, sys_rst_i, psel, penable, pwrite, pready, pslverr;
  logic aen, sh, tick, done;
  logic [7:0] paddr, trig;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] code;
  logic [3:0] ch;
  logic [1:0] rf;
  int mismatches = 0;
  int checks_done = 0;
  int cyc;
  sacc_ctrl sacc_ctrl_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .trigger_sources_i(trig),
    .conv_code_i(code), .input_channel_select_o(ch), .reference_select_o(rf),
    .analog_enable_o(aen), .sample_hold_o(sh), .conv_clk_en_o(tick), .conversion_done_o(done));
  sacc_analog_model sacc_analog_model_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .channel_i(ch), .reference_i(rf), .hold_i(sh), .code_o(code));
  // --------------------------------------------------------------------------
  // Bus, wait and compare tasks
  // --------------------------------------------------------------------------
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_done();
    cyc = 0;
    while (done !== 1'b1 && cyc < 4000) begin
      @(posedge clock_i);
      cyc++;
    end
    chk("completion wait", 1, cyc < 4000);
  endtask
  task automatic count_done(input int n);
    cyc = 0;
    repeat (n) begin
      @(posedge clock_i);
      if (done === 1'b1) cyc++;
    end
  endtask
  task automatic end_of_test();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    repeat (40000) @(posedge clock_i);
    mismatches++;
    end_of_test();
  end
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    {sys_rst_i, psel, penable, pwrite, paddr, pwdata, trig} = {1'b1, 3'b000, 8'h00, 32'h0, 8'h00};
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    chk("outputs after reset", 0, {aen, sh, tick, done, pslverr});
    apb(SACC_OFF_CTRL_A, 1'b0, 32'h0);
    chk("ctrl a reset", {24'h0, SACC_RST_CTRL_A}, rd);
    apb(8'h3c, 1'b1, 32'hff);
    apb(8'h3c, 1'b0, 32'h0);
    chk("unmapped read", 0, rd);
    apb(SACC_OFF_CTRL_A, 1'b1, EN | ST | PR);
    apb(SACC_OFF_CTRL_A, 1'b0, 32'h0);
    chk("enable refused in power reduction", {24'h0, SACC_RST_CTRL_A}, rd);
    apb(SACC_OFF_CTRL_A, 1'b1, 32'h0);
    apb(SACC_OFF_CTRL_A, 1'b1, EN | ST);
    wait_done();
    chk("first conversion length", 1, cyc inside {[48:60]});
    apb(SACC_OFF_CTRL_A, 1'b1, EN | ST | FL);
    wait_done();
    chk("normal conversion length", 1, cyc inside {[24:34]});
    apb(SACC_OFF_RES_LO, 1'b0, 32'h0);
    apb(SACC_OFF_RES_HI, 1'b0, 32'h0);
    foreach (rows[i]) begin
      apb(SACC_OFF_CHREF, 1'b1, {24'h0, rows[i].rf, rows[i].left, 1'b0, rows[i].ch});
      apb(SACC_OFF_CTRL_A, 1'b1, EN | ST | FL | {29'h0, rows[i].ps});
      apb(SACC_OFF_CTRL_A, 1'b0, 32'h0);
      chk("start bit busy", 1, rd[SACC_A_START]);
      wait_done();
      apb(SACC_OFF_CTRL_A, 1'b0, 32'h0);
      chk("start and flag after done", 1, {rd[SACC_A_START], rd[SACC_A_FLAG]});
      apb(SACC_OFF_RES_LO, 1'b0, 32'h0);
      chk("result low", {24'h0, rows[i].lo}, rd);
      apb(SACC_OFF_RES_HI, 1'b0, 32'h0);
      chk("result high", {24'h0, rows[i].hi}, rd);
    end
    apb(SACC_OFF_CHREF, 1'b1, 32'h43);
    apb(SACC_OFF_CTRL_A, 1'b1, EN | ST | FL);
    wait_done();
    apb(SACC_OFF_RES_LO, 1'b0, 32'h0);
    apb(SACC_OFF_CHREF, 1'b1, 32'h0f);
    apb(SACC_OFF_CTRL_A, 1'b1, EN | ST | FL);
    wait_done();
    apb(SACC_OFF_CTRL_A, 1'b0, 32'h0);
    chk("flag with locked result", 1, rd[SACC_A_FLAG]);
    apb(SACC_OFF_RES_HI, 1'b0, 32'h0);
    chk("locked high byte", 32'h01, rd);
    apb(SACC_OFF_RES_LO, 1'b0, 32'h0);
    chk("locked low byte", 32'h39, rd);
    apb(SACC_OFF_RES_HI, 1'b0, 32'h0);
    apb(SACC_OFF_CTRL_A, 1'b1, EN | ST | FL | 32'h3);
    repeat (8) @(posedge clock_i);
    apb(SACC_OFF_CHREF, 1'b1, 32'h43);
    wait_done();
    apb(SACC_OFF_RES_LO, 1'b0, 32'h0);
    chk("unlocked low byte, old channel", 32'hf9, rd);
    apb(SACC_OFF_RES_HI, 1'b0, 32'h0);
    apb(SACC_OFF_CTRL_A, 1'b1, EN | ST | FL);
    wait_done();
    apb(SACC_OFF_RES_LO, 1'b0, 32'h0);
    chk("new channel after conversion", 32'h39, rd);
    apb(SACC_OFF_RES_HI, 1'b0, 32'h0);
    apb(SACC_OFF_CTRL_B, 1'b1, 32'h1);
    apb(SACC_OFF_CTRL_A, 1'b1, EN | AU | FL);
    trig <= 8'h02;
    repeat (10) @(posedge clock_i);
    trig <= 8'h00;
    @(posedge clock_i);
    trig <= 8'h02;
    count_done(300);
    chk("one conversion per trigger", 1, cyc);
    apb(SACC_OFF_CTRL_A, 1'b1, EN | AU | ST | FL);
    count_done(300);
    chk("start bit under auto trigger", 1, cyc);
    trig <= 8'h00;
    apb(SACC_OFF_CTRL_B, 1'b1, 32'h0);
    apb(SACC_OFF_CTRL_A, 1'b1, EN | AU | ST | FL);
    count_done(200);
    chk("free running back to back", 1, cyc >= 6);
    apb(SACC_OFF_CTRL_A, 1'b0, 32'h0);
    chk("start high in free running", 1, rd[SACC_A_START]);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    chk("outputs after mid-run reset", 0, {aen, sh, tick, done});
    apb(SACC_OFF_CTRL_A, 1'b0, 32'h0);
    chk("ctrl a after mid-run reset", {24'h0, SACC_RST_CTRL_A}, rd);
    apb(SACC_OFF_CTRL_A, 1'b1, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
